// *** rtl/smcg_sleep_ctrl.sv ***
// What this block does
// - Six sleep modes, chosen by software mode select
// - Idle stops CPU, ADC and async timer; rest keeps running
// - Power-down stops oscillator and all functions
// - Power-down exits only on interrupt or reset
// - Power-save keeps only asynchronous timer clocked
// - ADC noise mode keeps ADC and async timer
// - Standby keeps main oscillator running, rest asleep
// - Extended standby keeps oscillator and async timer
`timescale 1ns/100ps
module smcg_sleep_ctrl import smcg_pkg::*; #(
	parameter int OSC_START_CYC = SMCG_OSC_START_CYC,
	parameter int FAST_START_CYC = SMCG_FAST_START_CYC
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic sleep_en_i,
	input wire logic [2:0] sleep_mode_i,
	input wire logic sleep_req_i,
	input wire logic irq_pending_i,
	output smcg_clk_en_t clk_en_o,
	output logic asleep_o,
	output logic cpu_resume_o,
	output logic mode_err_o
);

	localparam int TW = 16;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	// A zero count would never finish the wake wait
	if (OSC_START_CYC < 1 || OSC_START_CYC >= (1 << TW) ||
		FAST_START_CYC < 1 || FAST_START_CYC >= (1 << TW)) begin : g_bad_start
		$error("smcg_sleep_ctrl: start-up counts out of range");
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	smcg_state_t state;
	smcg_state_t next_state;
	logic [2:0] mode;
	smcg_clk_en_t next_clk_en;

	// Requested mode, as seen on the select inputs
	wire sel_idle = (sleep_mode_i == SMCG_MODE_IDLE);
	wire sel_adcnr = (sleep_mode_i == SMCG_MODE_ADCNR);
	wire sel_pdown = (sleep_mode_i == SMCG_MODE_PDOWN);
	wire sel_psave = (sleep_mode_i == SMCG_MODE_PSAVE);
	wire sel_stdby = (sleep_mode_i == SMCG_MODE_STDBY);
	wire sel_xstdby = (sleep_mode_i == SMCG_MODE_XSTDBY);
	wire mode_valid = sel_idle || sel_adcnr || sel_pdown || sel_psave ||
		sel_stdby || sel_xstdby;

	// ------------------------------------------------------------
	// State decode
	// ------------------------------------------------------------
	wire st_run = (state == SMCG_ST_RUN);
	wire st_sleep = (state == SMCG_ST_SLEEP);
	wire st_resume = (state == SMCG_ST_RESUME);

	// ------------------------------------------------------------
	// Request qualification
	// ------------------------------------------------------------
	wire req_seen = sleep_en_i && sleep_req_i;
	wire enter = req_seen && mode_valid;
	wire bad_req = req_seen && !mode_valid;
	// Only a legal request seen while running is taken
	wire take = st_run && enter;

	// Latched mode: a stopped oscillator needs the slow restart
	wire in_pdown = (mode == SMCG_MODE_PDOWN);
	wire in_psave = (mode == SMCG_MODE_PSAVE);
	wire osc_off = in_pdown || in_psave;
	wire wake_evt = irq_pending_i;

	smcg_clk_en_t sleep_en_map;
	always_comb begin
		sleep_en_map = '0;
		unique case (mode)
			SMCG_MODE_IDLE: begin
				sleep_en_map = SMCG_EN_ALL;
				sleep_en_map.cpu = 1'b0;
				sleep_en_map.adc = 1'b0;
				sleep_en_map.async_tmr = 1'b0;
			end
			SMCG_MODE_ADCNR: begin
				sleep_en_map.adc = 1'b1;
				sleep_en_map.async_tmr = 1'b1;
				sleep_en_map.irq = 1'b1;
				sleep_en_map.main_osc = 1'b1;
			end
			SMCG_MODE_PDOWN: begin
				sleep_en_map = '0;
			end
			SMCG_MODE_PSAVE: begin
				sleep_en_map.async_tmr = 1'b1;
			end
			SMCG_MODE_STDBY: begin
				sleep_en_map.main_osc = 1'b1;
			end
			SMCG_MODE_XSTDBY: begin
				sleep_en_map.main_osc = 1'b1;
				sleep_en_map.async_tmr = 1'b1;
			end
			default: begin
				sleep_en_map = SMCG_EN_ALL;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Wake timer
	// ------------------------------------------------------------
	wire timer_done;
	wire timer_load = st_sleep && wake_evt;
	wire [TW-1:0] start_cyc = osc_off ? TW'(OSC_START_CYC) : TW'(FAST_START_CYC);

	smcg_wake_timer #(
		.WIDTH(TW)
	) u_wake_timer (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.load_i(timer_load),
		.count_i(start_cyc),
		.done_o(timer_done)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_clk_en = clk_en_o;
		unique case (state)
			SMCG_ST_RUN: begin
				next_clk_en = SMCG_EN_ALL;
				if (enter) begin
					next_state = SMCG_ST_SLEEP;
				end
			end
			SMCG_ST_SLEEP: begin
				next_clk_en = sleep_en_map;
				if (wake_evt) begin
					next_state = SMCG_ST_WAKE;
					next_clk_en.main_osc = 1'b1;
				end
			end
			SMCG_ST_WAKE: begin
				next_clk_en.main_osc = 1'b1;
				if (timer_done) begin
					next_state = SMCG_ST_RESUME;
					next_clk_en = SMCG_EN_ALL;
				end
			end
			SMCG_ST_RESUME: begin
				next_clk_en = SMCG_EN_ALL;
				next_state = SMCG_ST_RUN;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Status decode
	// ------------------------------------------------------------
	wire next_asleep = (next_state != SMCG_ST_RUN);
	wire next_resume = st_resume && (next_state == SMCG_ST_RUN);
	wire next_mode_err = st_run && bad_req;

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= SMCG_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Mode latch
	// ------------------------------------------------------------
	// Held for the whole sleep so a changing select cannot alter the map
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode <= SMCG_MODE_RST;
		end else if (take) begin
			mode <= sleep_mode_i;
		end
	end

	// ------------------------------------------------------------
	// Clock enable register
	// ------------------------------------------------------------
	// Reset leaves every domain clocked, which is also a power-down exit
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			clk_en_o <= SMCG_EN_ALL;
		end else begin
			clk_en_o <= next_clk_en;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			asleep_o <= 1'b0;
			cpu_resume_o <= 1'b0;
			mode_err_o <= 1'b0;
		end else begin
			asleep_o <= next_asleep;
			cpu_resume_o <= next_resume;
			mode_err_o <= next_mode_err;
		end
	end

endmodule

// *** rtl/smcg_pkg.sv ***
package smcg_pkg;

	// Sleep mode selection codes
	localparam logic [2:0] SMCG_MODE_IDLE = 3'h0;
	localparam logic [2:0] SMCG_MODE_ADCNR = 3'h1;
	localparam logic [2:0] SMCG_MODE_PDOWN = 3'h2;
	localparam logic [2:0] SMCG_MODE_PSAVE = 3'h3;
	localparam logic [2:0] SMCG_MODE_STDBY = 3'h6;
	localparam logic [2:0] SMCG_MODE_XSTDBY = 3'h7;

	// Oscillator restart wait, in ns, and derived cycle count
	localparam int SMCG_CLK_PERIOD_NS = 5;
	localparam int SMCG_OSC_START_NS = 1000;
	localparam int SMCG_OSC_START_CYC =
		(SMCG_OSC_START_NS + SMCG_CLK_PERIOD_NS - 1) / SMCG_CLK_PERIOD_NS;
	// Fast restart when the oscillator kept running
	localparam int SMCG_FAST_START_CYC = 6;

	// Reset values
	localparam logic [2:0] SMCG_MODE_RST = SMCG_MODE_IDLE;

	// Clock enables per domain
	typedef struct packed {
		logic cpu;
		logic sram;
		logic timer;
		logic spi;
		logic irq;
		logic adc;
		logic async_tmr;
		logic main_osc;
	} smcg_clk_en_t;

	localparam smcg_clk_en_t SMCG_EN_ALL = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	typedef enum logic [3:0] {
		SMCG_ST_RUN = 4'h1,
		SMCG_ST_SLEEP = 4'h2,
		SMCG_ST_WAKE = 4'h4,
		SMCG_ST_RESUME = 4'h8
	} smcg_state_t;

endpackage

// *** rtl/smcg_wake_timer.sv ***
`timescale 1ns/100ps
module smcg_wake_timer import smcg_pkg::*; #(
	parameter int WIDTH = 16
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic load_i,
	input wire logic [WIDTH-1:0] count_i,
	output logic done_o
);

	logic [WIDTH-1:0] count;
	wire busy = (count != '0);

	// Counter must be at least one bit and stay within an int
	if (WIDTH < 1 || WIDTH > 31) begin : g_bad_width
		$error("smcg_wake_timer: WIDTH out of range");
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= busy && (count == {{(WIDTH-1){1'b0}}, 1'b1});
			if (load_i) begin
				count <= count_i;
			end else if (busy) begin
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// *** testbench/smcg_core_model.sv ***
`timescale 1ns/100ps
module smcg_core_model (
	input logic go_i,
	input logic asleep_i,
	output logic sleep_req_o
);
	// Asks only while awake; mode is set a cycle earlier
	assign sleep_req_o = go_i & !asleep_i;
endmodule

// *** testbench/smcg_chk.sv ***
`timescale 1ns/100ps
module smcg_chk import smcg_pkg::*; (
	input logic clk_sys_i,
	input logic resetn_i,
	input logic sleep_en_i,
	input logic [2:0] sleep_mode_i,
	input logic sleep_req_i,
	input logic irq_pending_i,
	input smcg_clk_en_t clk_en_o,
	input logic asleep_o,
	input logic cpu_resume_o,
	input logic mode_err_o
);
	wire tk = sleep_en_i & sleep_req_i & !asleep_o;
	wire q = !irq_pending_i;
	wire [2:0] m = sleep_mode_i;
	wire [7:0] c = clk_en_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	property p_sel; tk && (m == 3'h4 || m == 3'h5) |=> mode_err_o && !asleep_o; endproperty
	a_sel: assert property (p_sel) else $error("bad mode slept");
	property p_idl; tk && m == 3'h0 ##1 q |=> c == 8'h79; endproperty
	a_idl: assert property (p_idl) else $error("idle map");
	property p_pdn; tk && m == 3'h2 ##1 q |=> c == 8'h00; endproperty
	a_pdn: assert property (p_pdn) else $error("power-down map");
	property p_hld; c == 8'h00 && q |=> c == 8'h00; endproperty
	a_hld: assert property (p_hld) else $error("left power-down");
	property p_psv; tk && m == 3'h3 ##1 q |=> c == 8'h02; endproperty
	a_psv: assert property (p_psv) else $error("power-save map");
	property p_adc; tk && m == 3'h1 ##1 q |=> c == 8'h0f; endproperty
	a_adc: assert property (p_adc) else $error("adc map");
	property p_stb; tk && m == 3'h6 ##1 q |=> c == 8'h01; endproperty
	a_stb: assert property (p_stb) else $error("standby map");
	property p_xst; tk && m == 3'h7 ##1 q |=> c == 8'h03; endproperty
	a_xst: assert property (p_xst) else $error("ext standby map");
endmodule
bind smcg_sleep_ctrl smcg_chk u_chk (.clk_sys_i, .resetn_i, .sleep_en_i, .sleep_mode_i,
	.sleep_req_i, .irq_pending_i, .clk_en_o, .asleep_o, .cpu_resume_o, .mode_err_o);

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic go = 1'b0;
	logic en = 1'b1;
	logic irq = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [31:0] r = 32'h2a5ede91;
	wire req, slp, res, err;
	wire [7:0] ce;
	int mismatches, n_checks, cyc, k;
	always #2.5 clk_sys_i = ~clk_sys_i;
	smcg_core_model core (.go_i(go), .asleep_i(slp), .sleep_req_o(req));
	smcg_sleep_ctrl #(.OSC_START_CYC(4), .FAST_START_CYC(2)) uut (.clk_sys_i, .resetn_i,
		.sleep_en_i(en), .sleep_mode_i(mode), .sleep_req_i(req), .irq_pending_i(irq),
		.clk_en_o(ce), .asleep_o(slp), .cpu_resume_o(res), .mode_err_o(err));
	function automatic logic [31:0] nx(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected clock map per mode; all ones means refused
	function automatic logic [7:0] mp(int m);
		case (m)
			0: return 8'h79;
			1: return 8'h0f;
			2: return 8'h00;
			3: return 8'h02;
			6: return 8'h01;
			7: return 8'h03;
			default: return 8'hff;
		endcase
	endfunction
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic summarize;
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			summarize;
		end
	end
	initial begin
		repeat (2) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		chk({1'b0, ce}, 9'h0ff);
		for (int i = 0; i < 16; i++) begin
			r = nx(r);
			k = i < 8 ? i : int'(r[2:0]);
			mode = k[2:0];
			@(negedge clk_sys_i);
			go = 1'b1;
			@(negedge clk_sys_i);
			go = 1'b0;
			chk({8'h0, mp(k) == 8'hff ? err : slp}, 9'h001);
			@(negedge clk_sys_i);
			chk({1'b0, ce}, {1'b0, mp(k)});
			repeat (r[4:0]) @(negedge clk_sys_i);
			chk({slp, ce}, {mp(k) != 8'hff, mp(k)});
			irq = 1'b1;
			@(negedge clk_sys_i);
			for (int t = 0; t < 300 && res !== 1'b1 && mp(k) != 8'hff; t++)
				@(negedge clk_sys_i);
			irq = 1'b0;
			chk({res, ce}, {mp(k) != 8'hff, 8'hff});
		end
		// Hardware reset is the other way out of power-down
		mode = 3'h2;
		@(negedge clk_sys_i);
		go = 1'b1;
		@(negedge clk_sys_i);
		go = 1'b0;
		@(negedge clk_sys_i);
		chk({slp, ce}, 9'h100);
		resetn_i = 1'b0;
		@(negedge clk_sys_i);
		chk({slp, ce}, 9'h0ff);
		resetn_i = 1'b1;
		// Sleep enable low refuses a legal request
		en = 1'b0;
		@(negedge clk_sys_i);
		go = 1'b1;
		@(negedge clk_sys_i);
		go = 1'b0;
		chk({slp, ce}, 9'h0ff);
		chk({8'h0, err}, 9'h000);
		summarize;
	end
endmodule
